/* mscc_pkg.sv */
// Package for the module standby and clock output control block
`default_nettype none
package mscc_pkg;
    // Register byte addresses on APB
    localparam logic [7:0] MSCC_STOP_CTRL_ADDR  = 8'h00;
    localparam logic [7:0] MSCC_STATUS_ADDR     = 8'h04;
    localparam logic [7:0] MSCC_OPSTATE_ADDR    = 8'h08;
    // Field layout of the module stop control register
    localparam int MSCC_NUM_UNITS  = 6;
    localparam int MSCC_CLKSTOP_POS = 7;
    localparam int MSCC_DMA_POS     = 2;
    localparam int MSCC_REFRESH_POS = 1;
    localparam logic [7:0] MSCC_CTRL_RESET = 8'h00;
    localparam logic [7:0] MSCC_CTRL_WMASK = 8'hBF;
    // Value a halted unit returns on reads
    localparam logic [7:0] MSCC_STANDBY_READ = 8'hFF;
    localparam logic [31:0] MSCC_ZERO32 = 32'h00000000;

    // Chip operating states seen by the clock output pin
    typedef enum logic [1:0] {
        MSCC_OP_NORMAL,
        MSCC_OP_SLEEP,
        MSCC_OP_SW_STANDBY,
        MSCC_OP_HW_STANDBY
    } mscc_opstate_e;

    // Peripheral register access from the internal bus
    typedef struct packed {
        logic       sel;
        logic       wr;
        logic [2:0] unit;
        logic [7:0] wdata;
    } mscc_periph_req_s;

    // Clock output pin as two signals: level and output enable
    typedef struct packed {
        logic o;
        logic oe;
    } mscc_clk_pin_s;
endpackage
`default_nettype wire

/* mscc_unit_gate.sv */
// Per-unit standby gate: halt, reset and access blocking for one peripheral
`default_nettype none
module mscc_unit_gate
    import mscc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       stop_bit,
    input  wire logic       acc_sel,
    input  wire logic       acc_wr,
    input  wire logic [7:0] unit_rdata,
    output logic            unit_halt_q,
    output logic            unit_reset,
    output logic            unit_wr_en,
    output logic            pin_func_en,
    output logic [7:0]      gated_rdata_q
);
    logic halt_d;

    // Halt takes effect one core clock after the stop bit is set, two after the control write cycle
    assign halt_d = stop_bit;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            unit_halt_q <= 1'b0;
        end else begin
            unit_halt_q <= halt_d;
        end
    end

    // Unit registers held at reset values for the whole standby period
    assign unit_reset  = rst | unit_halt_q;
    // Writes dropped while halted
    assign unit_wr_en  = acc_sel & acc_wr & ~unit_halt_q;
    // Pins fall back to the port logic when halted
    assign pin_func_en = ~unit_halt_q;

    // Registered read data, all ones in standby
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gated_rdata_q <= 8'h00;
        end else if (acc_sel && !acc_wr) begin
            gated_rdata_q <= unit_halt_q ? MSCC_STANDBY_READ : unit_rdata;
        end
    end

    a_halt_follows_bit: assert property (@(posedge core_clk) disable iff (rst)
        stop_bit |=> unit_halt_q) else $error("unit did not halt");
    a_write_blocked: assert property (@(posedge core_clk) disable iff (rst)
        unit_halt_q |-> !unit_wr_en) else $error("write passed in standby");
    a_read_all_ones: assert property (@(posedge core_clk) disable iff (rst)
        (acc_sel && !acc_wr && unit_halt_q) |=> gated_rdata_q == MSCC_STANDBY_READ)
        else $error("standby read not all ones");
    a_reset_held: assert property (@(posedge core_clk) disable iff (rst)
        unit_halt_q |-> unit_reset && !pin_func_en) else $error("unit not reset");
endmodule
`default_nettype wire

/* mscc_top.sv */
// Module standby and system clock output control with APB register access
//
// Design decisions made here: the address map and register access over APB.
`default_nettype none
module mscc_top
    import mscc_pkg::*;
#(
    parameter int NUM_UNITS = MSCC_NUM_UNITS
)(
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    // Master of the current APB cycle is the DMA controller
    input  wire logic                  bus_master_dma,
    // Operating state and clock source
    input  wire logic [1:0]            op_state,
    input  wire logic                  sys_clk_src,
    // Bus requests from DMA and refresh units, for checking only
    input  wire logic                  dma_bus_req,
    input  wire logic                  refresh_bus_req,
    // Peripheral register access
    input  wire mscc_periph_req_s      periph_req,
    input  wire logic [8*NUM_UNITS-1:0] unit_rdata,
    output logic [7:0]                 periph_rdata,
    output logic [NUM_UNITS-1:0]       unit_halt,
    output logic [NUM_UNITS-1:0]       unit_reset,
    output logic [NUM_UNITS-1:0]       unit_wr_en,
    output logic [NUM_UNITS-1:0]       pin_func_en,
    // Clock output pin
    output var mscc_clk_pin_s          clk_pin
);
    logic [7:0]           module_stop_control_reg_q;
    logic [7:0]           ctrl_d;
    logic [NUM_UNITS-1:0] unit_stop_bits;
    logic                 clock_out_stop_bit;
    logic                 dma_unit_stop_bit;
    logic                 refresh_unit_stop_bit;
    logic                 apb_access;
    logic                 apb_wr;
    logic                 ctrl_wr;
    logic [31:0]          rdata_d;
    logic [7:0]           unit_rdq [NUM_UNITS];
    logic [2:0]           rd_unit_q;
    logic                 clk_gate_q;
    logic [1:0]           op_q;
    mscc_opstate_e        op_e;

    // Decode one register hit
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
        return a == r;
    endfunction

    // APB answers in the access phase with no wait states
    assign pready     = 1'b1;
    assign apb_access = psel & penable;
    assign apb_wr     = apb_access & pwrite;
    assign pslverr    = apb_access & ~(addr_hit(paddr, MSCC_STOP_CTRL_ADDR)
                        | addr_hit(paddr, MSCC_STATUS_ADDR)
                        | addr_hit(paddr, MSCC_OPSTATE_ADDR));

    // CPU-only write path; a DMA master may only read
    assign ctrl_wr = apb_wr & addr_hit(paddr, MSCC_STOP_CTRL_ADDR) & ~bus_master_dma;
    assign ctrl_d  = pwdata[7:0] & MSCC_CTRL_WMASK;

    // Stop control register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            module_stop_control_reg_q <= MSCC_CTRL_RESET;
        end else if (ctrl_wr) begin
            module_stop_control_reg_q <= ctrl_d;
        end
    end

    assign unit_stop_bits        = module_stop_control_reg_q[NUM_UNITS-1:0];
    assign clock_out_stop_bit    = module_stop_control_reg_q[MSCC_CLKSTOP_POS];
    assign dma_unit_stop_bit     = unit_stop_bits[MSCC_DMA_POS];
    assign refresh_unit_stop_bit = unit_stop_bits[MSCC_REFRESH_POS];

    // Read data mux ahead of the prdata register; reserved bits read as zero
    always_comb begin
        rdata_d = MSCC_ZERO32;
        if (addr_hit(paddr, MSCC_STOP_CTRL_ADDR)) begin
            rdata_d[7:0] = module_stop_control_reg_q;
        end else if (addr_hit(paddr, MSCC_STATUS_ADDR)) begin
            rdata_d[NUM_UNITS-1:0] = unit_halt;
        end else if (addr_hit(paddr, MSCC_OPSTATE_ADDR)) begin
            rdata_d[1:0] = op_q;
        end
    end

    // Setup-phase capture so prdata is valid through the access phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= MSCC_ZERO32;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_d;
        end
    end

    // One standby gate per unit
    genvar gi;
    generate
        for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
            mscc_unit_gate u_gate (
                .core_clk      (core_clk),
                .rst           (rst),
                .stop_bit      (unit_stop_bits[gi]),
                .acc_sel       (periph_req.sel && periph_req.unit == 3'(gi)),
                .acc_wr        (periph_req.wr),
                .unit_rdata    (unit_rdata[8*gi +: 8]),
                .unit_halt_q   (unit_halt[gi]),
                .unit_reset    (unit_reset[gi]),
                .unit_wr_en    (unit_wr_en[gi]),
                .pin_func_en   (pin_func_en[gi]),
                .gated_rdata_q (unit_rdq[gi])
            );
        end
    endgenerate

    // Which unit the last peripheral read addressed
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_unit_q <= 3'h0;
        end else if (periph_req.sel && !periph_req.wr) begin
            rd_unit_q <= periph_req.unit;
        end
    end

    // Out-of-range units read as all ones
    always_comb begin
        periph_rdata = MSCC_STANDBY_READ;
        for (int i = 0; i < NUM_UNITS; i++) begin
            if (rd_unit_q == 3'(i)) begin
                periph_rdata = unit_rdq[i];
            end
        end
    end

    // Operating state from other power logic on this clock
    always_ff @(posedge core_clk) begin
        if (rst) begin
            op_q <= 2'h0;
        end else begin
            op_q <= op_state;
        end
    end
    assign op_e = mscc_opstate_e'(op_q);

    // Gate enable updates once per core clock; a source not tied to core_clk may glitch
    always_ff @(posedge core_clk) begin
        if (rst) begin
            clk_gate_q <= 1'b0;
        end else begin
            clk_gate_q <= ~clock_out_stop_bit
                && (op_e == MSCC_OP_NORMAL || op_e == MSCC_OP_SLEEP);
        end
    end

    // Clock pin state by operating state and stop bit
    always_comb begin
        clk_pin.o  = 1'b0;
        clk_pin.oe = 1'b0;
        if (clock_out_stop_bit) begin
            clk_pin.oe = 1'b0;
        end else begin
            case (op_e)
                MSCC_OP_NORMAL, MSCC_OP_SLEEP: begin
                    clk_pin.oe = 1'b1;
                    clk_pin.o  = sys_clk_src & clk_gate_q;
                end
                MSCC_OP_SW_STANDBY: begin
                    clk_pin.oe = 1'b1;
                    clk_pin.o  = 1'b1;
                end
                MSCC_OP_HW_STANDBY: begin
                    clk_pin.oe = 1'b0;
                end
                default: begin
                    clk_pin.oe = 1'b0;
                end
            endcase
        end
    end

    // Checks
    a_dma_write_ignored: assert property (@(posedge core_clk) disable iff (rst)
        (apb_wr && bus_master_dma) |=> $stable(module_stop_control_reg_q))
        else $error("DMA master changed stop register");
    a_cpu_write_lands: assert property (@(posedge core_clk) disable iff (rst)
        ctrl_wr |=> module_stop_control_reg_q == $past(ctrl_d))
        else $error("CPU write lost");
    sequence s_stop_write;
        ctrl_wr && ctrl_d[0];
    endsequence
    sequence s_halt_next;
        ##1 unit_stop_bits[0] ##1 unit_halt[0];
    endsequence
    a_halt_timing: assert property (@(posedge core_clk) disable iff (rst)
        s_stop_write |-> s_halt_next) else $error("halt timing wrong");
    a_clk_hiz_stop: assert property (@(posedge core_clk) disable iff (rst)
        clock_out_stop_bit |-> !clk_pin.oe) else $error("clock pin driven while stopped");
    a_clk_sw_high: assert property (@(posedge core_clk) disable iff (rst)
        (!clock_out_stop_bit && op_e == MSCC_OP_SW_STANDBY) |-> clk_pin.oe && clk_pin.o)
        else $error("clock pin not high in software standby");
    a_clk_hw_hiz: assert property (@(posedge core_clk) disable iff (rst)
        op_e == MSCC_OP_HW_STANDBY |-> !clk_pin.oe) else $error("clock pin driven in hw standby");
    a_clk_run: assert property (@(posedge core_clk) disable iff (rst)
        (!clock_out_stop_bit && op_e == MSCC_OP_NORMAL) [*2] |-> clk_pin.oe
            && clk_pin.o == sys_clk_src) else $error("clock not output");
    a_pins_revert: assert property (@(posedge core_clk) disable iff (rst)
        unit_halt[0] |-> !pin_func_en[0]) else $error("pin kept function");
    a_dma_stop_quiet: assert property (@(posedge core_clk) disable iff (rst)
        $rose(dma_unit_stop_bit) |-> !$past(dma_bus_req))
        else $error("DMA stopped with request pending");
    a_ref_stop_quiet: assert property (@(posedge core_clk) disable iff (rst)
        $rose(refresh_unit_stop_bit) |-> !$past(refresh_bus_req))
        else $error("refresh stopped with request pending");
endmodule
`default_nettype wire

/* mscc_periph_model.sv */
// Behavioural model of the six peripheral units behind the standby gates
`default_nettype none
module mscc_periph_model
    import mscc_pkg::*;
(
    input  wire logic             core_clk,
    input  wire mscc_periph_req_s periph_req,
    input  wire logic [5:0]       unit_reset,
    input  wire logic [5:0]       unit_wr_en,
    output logic [47:0]           unit_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    // One byte per unit; reset wins so a halted unit forgets its setup
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 6; i++) begin
            if (unit_reset[i]) begin
                unit_rdata[8*i +: 8] <= 8'h00;
            end else if (unit_wr_en[i]) begin
                unit_rdata[8*i +: 8] <= periph_req.wdata;
            end
        end
    end
endmodule
`default_nettype wire

/* test_module_standby_clock_out_ctrl.sv */
// Testbench for the module standby and clock output control block
`default_nettype none
module test_module_standby_clock_out_ctrl
    import mscc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic             core_clk, rst, psel, penable, pwrite, pready, pslverr, er;
    logic             bus_master_dma, sys_clk_src, dma_bus_req, refresh_bus_req;
    logic [7:0]       paddr, periph_rdata;
    logic [31:0]      pwdata, prdata, rd;
    logic [1:0]       op_state;
    logic [47:0]      unit_rdata;
    logic [5:0]       unit_halt, unit_reset, unit_wr_en, pin_func_en;
    mscc_periph_req_s periph_req;
    mscc_clk_pin_s    clk_pin;
    int               n_mismatch = 0;
    int               compares = 0;

    mscc_top dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .pslverr, .prdata, .bus_master_dma, .op_state, .sys_clk_src, .dma_bus_req,
        .refresh_bus_req, .periph_req, .unit_rdata, .periph_rdata, .unit_halt,
        .unit_reset, .unit_wr_en, .pin_func_en, .clk_pin);
    mscc_periph_model units (.core_clk, .periph_req, .unit_reset, .unit_wr_en, .unit_rdata);

    // Clock at 100 ns period
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic finish_test;
        if (n_mismatch == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // APB transfer; waits for pready, data taken at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pw(input logic [2:0] u, input logic [7:0] d, input logic en);
        @(posedge core_clk);
        periph_req <= {2'h3, u, d};
        #1 chk("wr_en", 32'(en) << u, unit_wr_en);
        @(posedge core_clk);
        periph_req <= '0;
    endtask

    task automatic pr(input logic [2:0] u, input logic [7:0] e);
        @(posedge core_clk);
        periph_req <= {2'h2, u, 8'h00};
        @(posedge core_clk);
        periph_req <= '0;
        #1 chk("periph_rd", e, periph_rdata);
    endtask

    // Reserved bit, status view and an unmapped address
    task automatic t_regs;
        apb(1'b1, MSCC_STOP_CTRL_ADDR, 32'hFFFFFFFF);
        apb(1'b0, MSCC_STOP_CTRL_ADDR, 32'h00000000);
        chk("ctrl", 32'h000000BF, rd);
        apb(1'b0, MSCC_STATUS_ADDR, 32'h00000000);
        chk("status", 32'h0000003F, rd);
        apb(1'b0, 8'h0C, 32'h00000000);
        chk("slverr", 32'h00000001, er);
        apb(1'b1, MSCC_STOP_CTRL_ADDR, 32'h00000000);
    endtask

    // Mid-run reset clears the stop register and every halt
    task automatic t_reset;
        apb(1'b1, MSCC_STOP_CTRL_ADDR, 32'h0000003F);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        #1 chk("rst_halt", 32'h00000000, unit_halt);
        apb(1'b0, MSCC_STOP_CTRL_ADDR, 32'h00000000);
        chk("rst_ctrl", 32'h00000000, rd);
    endtask

    // Writes by the DMA master must not stop anything, its reads still work
    task automatic t_dma;
        apb(1'b1, MSCC_STOP_CTRL_ADDR, 32'h00000080);
        bus_master_dma <= 1'b1;
        dma_bus_req <= 1'b1;
        refresh_bus_req <= 1'b1;
        apb(1'b1, MSCC_STOP_CTRL_ADDR, 32'h0000003F);
        apb(1'b0, MSCC_STOP_CTRL_ADDR, 32'h00000000);
        chk("dma_rd", 32'h00000080, rd);
        bus_master_dma <= 1'b0;
        dma_bus_req <= 1'b0;
        refresh_bus_req <= 1'b0;
        #1 chk("dma_halt", 32'h00000000, unit_halt);
    endtask

    // Program, stop, probe, restart and reprogram one unit
    task automatic t_unit(input logic [2:0] u);
        logic [5:0] m;
        m = 6'h01 << u;
        pw(u, 8'hA0 | u, 1'b1);
        pr(u, 8'hA0 | u);
        // Unit interrupts are taken as already off here
        apb(1'b1, MSCC_STOP_CTRL_ADDR, 32'(m));
        #1 chk("halt_early", 32'h00000000, unit_halt);
        @(posedge core_clk);
        #1 chk("halt", m, unit_halt);
        chk("pin_func", 6'(~m), pin_func_en);
        chk("unit_reset", m, unit_reset);
        pr(u, MSCC_STANDBY_READ);
        pw(u, 8'h5A, 1'b0);
        apb(1'b1, MSCC_STOP_CTRL_ADDR, 32'h00000000);
        pr(u, 8'h00);
        pw(u, 8'h3C, 1'b1);
        pr(u, 8'h3C);
    endtask

    // Clock pin in every operating state with the stop bit both ways
    task automatic t_clk;
        logic oe;
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, MSCC_STOP_CTRL_ADDR, 32'(s) << MSCC_CLKSTOP_POS);
            for (int op = 0; op < 4; op++) begin
                for (int c = 0; c < 2; c++) begin
                    @(posedge core_clk);
                    op_state <= 2'(op);
                    sys_clk_src <= 1'(c);
                    repeat (3) @(posedge core_clk);
                    oe = (s == 0) && (op != 3);
                    #1 chk("clk_oe", oe, clk_pin.oe);
                    if (oe) chk("clk_o", (op == 2) ? 1 : c, clk_pin.o);
                    apb(1'b0, MSCC_OPSTATE_ADDR, 32'h00000000);
                    chk("opstate", 32'(op), rd);
                end
            end
        end
    endtask

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        finish_test;
    end

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        bus_master_dma = 1'b0;
        op_state = 2'h0;
        sys_clk_src = 1'b0;
        dma_bus_req = 1'b0;
        refresh_bus_req = 1'b0;
        periph_req = '0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        t_regs;
        t_reset;
        t_dma;
        for (int u = 0; u < 6; u++) t_unit(3'(u));
        t_clk;
        finish_test;
    end
endmodule
`default_nettype wire
